//--- sensor_mode_seq.sv
// Power mode sequencer and conversion pacing for the three-axis sensor.
`timescale 1ns/10ps
module sensor_mode_seq import sensor_seq_pkg::*; #(
  parameter int POWER_UP_CNT = POWER_UP_CYCLES,
  parameter int SLOT_CNT     = CONV_SLOT_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  // Pins
  input  wire logic       supply_ok,
  input  wire logic       scl_pin,
  // From the target interface logic
  input  wire logic       addr_match,
  input  wire sense_cfg_s cfg,
  // Status
  output seq_status_s     status,
  output logic [7:0]      temp_coefficient
);

  localparam logic [CNT_W-1:0] PU_LOAD    = CNT_W'(POWER_UP_CNT - 1);
  localparam logic [CNT_W-1:0] WAKE_LOAD  = CNT_W'(WAKE_CYCLES - 1);
  localparam logic [CNT_W-1:0] MEAS_LOAD  = CNT_W'(START_MEAS_CYCLES - 1);
  localparam logic [CNT_W-1:0] SLEEP_LOAD = CNT_W'(GO_SLEEP_CYCLES - 1);

  typedef struct packed {
    mode_e            mode;
    logic [CNT_W-1:0] timer;
    logic             sleep_armed;
    logic             conv_start;
    seq_status_s      status;
    logic [7:0]       tempco;
  } seq_state_s;

  seq_state_s q;
  seq_state_s d;

  logic supply_ok_s;
  logic scl_s;
  logic conv_busy;
  logic conv_done;

  bit_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .async_in ({supply_ok, scl_pin}),
    .sync_out ({supply_ok_s, scl_s})
  );

  conv_timer #(
    .SLOT_CYCLES (SLOT_CNT)
  ) u_conv_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .start   (q.conv_start),
    .abort   (q.mode != M_MEASURE),
    .avg_sel (cfg.conversion_averaging_select),
    .mag_en  (cfg.mag_channel_enable),
    .busy    (conv_busy),
    .done    (conv_done)
  );

  function automatic logic [7:0] tempco_value(input logic [1:0] sel);
    logic [7:0] v;
    v = TEMPCO_VAL_NONE;
    unique case (sel)
      TEMPCO_NONE:     v = TEMPCO_VAL_NONE;
      TEMPCO_LOW:      v = TEMPCO_VAL_LOW;
      TEMPCO_RESERVED: v = TEMPCO_VAL_NONE;
      TEMPCO_HIGH:     v = TEMPCO_VAL_HIGH;
    endcase
    return v;
  endfunction

  always_comb begin
    d = q;
    if (clk_en) begin
      d.conv_start          = 1'b0;
      d.status.wake_event   = 1'b0;
      d.status.result_valid = 1'b0;
      // Re-arm only after the host leaves the sleep code, so a wake is not undone
      if (cfg.op_mode != OPMODE_SLEEP) begin
        d.sleep_armed = 1'b1;
      end
      if (!supply_ok_s) begin
        // Supply below minimum: hold the start-up count at its full length
        d.mode  = M_POWER_UP;
        d.timer = PU_LOAD;
      end else begin
        unique case (q.mode)
          M_POWER_UP: begin
            if (q.timer == '0) begin
              d.mode = M_STANDBY;
            end else begin
              d.timer = q.timer - CNT_W'(1);
            end
          end
          M_STANDBY: begin
            if (cfg.op_mode == OPMODE_CONTINUOUS) begin
              d.mode  = M_START_MEAS;
              d.timer = MEAS_LOAD;
            end else if (cfg.op_mode == OPMODE_SLEEP && q.sleep_armed) begin
              d.mode        = M_GO_SLEEP;
              d.timer       = SLEEP_LOAD;
              d.sleep_armed = 1'b0;
            end
          end
          M_START_MEAS: begin
            if (cfg.op_mode != OPMODE_CONTINUOUS) begin
              d.mode = M_STANDBY;
            end else if (q.timer == '0) begin
              d.mode = M_MEASURE;
            end else begin
              d.timer = q.timer - CNT_W'(1);
            end
          end
          M_MEASURE: begin
            if (cfg.op_mode != OPMODE_CONTINUOUS) begin
              d.mode = M_STANDBY;
            end else if (!conv_busy && !q.conv_start) begin
              d.conv_start = 1'b1;
            end
            // Results only at the end of a whole interval
            d.status.result_valid = conv_done;
          end
          M_GO_SLEEP: begin
            // The delay runs only while the clock line stays high
            if (!scl_s) begin
              d.timer = SLEEP_LOAD;
            end else if (q.timer == '0) begin
              d.mode = M_SLEEP;
            end else begin
              d.timer = q.timer - CNT_W'(1);
            end
          end
          M_SLEEP: begin
            if (addr_match) begin
              d.mode              = M_WAKING;
              d.timer             = WAKE_LOAD;
              d.status.wake_event = 1'b1;
            end
          end
          M_WAKING: begin
            if (q.timer == '0) begin
              d.mode = M_STANDBY;
            end else begin
              d.timer = q.timer - CNT_W'(1);
            end
          end
        endcase
      end
      d.status.mode        = d.mode;
      d.status.i2c_respond = (d.mode == M_STANDBY) || (d.mode == M_MEASURE);
      d.status.conv_busy   = conv_busy;
      d.tempco             = tempco_value(cfg.magnet_temp_coefficient_select);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q             <= '0;
      q.mode        <= MODE_RESET;
      q.timer       <= PU_LOAD;
      q.status.mode <= MODE_RESET;
    end else begin
      q <= d;
    end
  end

  assign status           = q.status;
  assign temp_coefficient = q.tempco;

  // Checking aids: enabled cycles spent in the current mode, and the run of
  // clock-line-high cycles while heading for sleep
  int dwell_q;
  int high_run_q;

  // Supply low holds the start-up count at full length, so the dwell restarts too
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dwell_q    <= 0;
      high_run_q <= 0;
    end else if (clk_en) begin
      dwell_q    <= (d.mode != q.mode || !supply_ok_s) ? 0 : dwell_q + 1;
      high_run_q <= (q.mode == M_GO_SLEEP && scl_s) ? high_run_q + 1 : 0;
    end
  end

  sequence s_left_power_up;
    $past(q.mode) == M_POWER_UP && q.mode == M_STANDBY;
  endsequence

  sequence s_wake_accept;
    q.mode == M_SLEEP && supply_ok_s && addr_match && clk_en;
  endsequence

  sequence s_wake_report;
    q.mode == M_WAKING && status.wake_event && !status.i2c_respond;
  endsequence

  a_power_up_time: assert property (@(posedge clk) disable iff (!reset_n)
    s_left_power_up |-> $past(dwell_q) == POWER_UP_CNT - 1)
    else $error("power-up start interval wrong");

  a_wake_time: assert property (@(posedge clk) disable iff (!reset_n)
    ($past(q.mode) == M_WAKING && q.mode == M_STANDBY) |-> $past(dwell_q) == WAKE_CYCLES - 1)
    else $error("sleep to standby interval wrong");

  a_meas_start: assert property (@(posedge clk) disable iff (!reset_n)
    ($past(q.mode) == M_START_MEAS && q.mode == M_MEASURE)
      |-> $past(dwell_q) == START_MEAS_CYCLES - 1)
    else $error("standby to measure interval wrong");

  a_sleep_entry: assert property (@(posedge clk) disable iff (!reset_n)
    ($past(q.mode) == M_GO_SLEEP && q.mode == M_SLEEP)
      |-> $past(scl_s) && $past(high_run_q) == GO_SLEEP_CYCLES - 1)
    else $error("sleep entered without a full clock-high interval");

  a_respond_modes: assert property (@(posedge clk) disable iff (!reset_n)
    status.i2c_respond |-> (q.mode == M_STANDBY || q.mode == M_MEASURE))
    else $error("answering outside standby or measure");

  a_sleep_no_ack: assert property (@(posedge clk) disable iff (!reset_n)
    s_wake_accept |=> s_wake_report)
    else $error("wake address not handled silently");

  a_tempco_map: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en |=> temp_coefficient == ($past(cfg.magnet_temp_coefficient_select) == TEMPCO_HIGH
      ? TEMPCO_VAL_HIGH : ($past(cfg.magnet_temp_coefficient_select) == TEMPCO_LOW
      ? TEMPCO_VAL_LOW : TEMPCO_VAL_NONE)))
    else $error("compensation coefficient wrong");

  a_result_gate: assert property (@(posedge clk) disable iff (!reset_n)
    status.result_valid |-> $past(conv_done) && $past(q.mode) == M_MEASURE)
    else $error("result without completed conversion");

  a_result_pulse: assert property (@(posedge clk) disable iff (!reset_n)
    (status.result_valid && clk_en) |=> !status.result_valid)
    else $error("result valid longer than a cycle");

endmodule

//--- sensor_seq_pkg.sv
// Shared constants, mode and status types for the magnetic sensor sequencer.
// Operation
// - Compensation code 00b none, 01b 0.12 %/C, 11b 0.2 %/C, all three axes.
// - After supply reaches its minimum, standby follows a 270 us start-up.
// - Wake from sleep reaches standby within 50 us.
// - Standby to continuous measure takes 70 us before measuring starts.
// - Continuous mode, one channel: 50 us at averaging 000b, 825 us at 101b.
// - Averaging 000b: each further magnetic channel adds 25 us.
// - Averaging 000b: temperature channel enable does not change conversion time.
// - Averaging 101b: 32 samples per channel, each further channel adds 800 us.
// - Sleep is entered 20 us after the serial clock line returns high.
// - Host transactions are answered only in standby or continuous measure.
// - In sleep, own address wakes the device but is not acknowledged.
package sensor_seq_pkg;

  // Timing, in microseconds and core clock rate
  localparam int CLK_MHZ          = 40;
  localparam int T_POWER_UP_US    = 270;
  localparam int T_WAKE_US        = 50;
  localparam int T_START_MEAS_US  = 70;
  localparam int T_GO_SLEEP_US    = 20;
  // One sample slot; a conversion is one slot of overhead plus one per sample
  localparam int T_CONV_SLOT_US   = 25;
  localparam int AVG_MAX_SAMPLES  = 32;

  localparam int POWER_UP_CYCLES   = T_POWER_UP_US * CLK_MHZ;
  localparam int WAKE_CYCLES       = T_WAKE_US * CLK_MHZ;
  localparam int START_MEAS_CYCLES = T_START_MEAS_US * CLK_MHZ;
  localparam int GO_SLEEP_CYCLES   = T_GO_SLEEP_US * CLK_MHZ;
  localparam int CONV_SLOT_CYCLES  = T_CONV_SLOT_US * CLK_MHZ;

  // Longest conversion is 97 slots, 97000 cycles
  localparam int CNT_W = 17;

  // Operating mode codes
  localparam logic [1:0] OPMODE_STANDBY    = 2'h0;
  localparam logic [1:0] OPMODE_SLEEP      = 2'h1;
  localparam logic [1:0] OPMODE_CONTINUOUS = 2'h2;

  // Averaging codes
  localparam logic [2:0] AVG_SINGLE = 3'h0;
  localparam logic [2:0] AVG_MAX    = 3'h5;

  // Compensation select codes and coefficients in 0.01 %/C
  localparam logic [1:0] TEMPCO_NONE     = 2'h0;
  localparam logic [1:0] TEMPCO_LOW      = 2'h1;
  localparam logic [1:0] TEMPCO_RESERVED = 2'h2;
  localparam logic [1:0] TEMPCO_HIGH     = 2'h3;
  localparam logic [7:0] TEMPCO_VAL_NONE = 8'h00;
  localparam logic [7:0] TEMPCO_VAL_LOW  = 8'h0c;
  localparam logic [7:0] TEMPCO_VAL_HIGH = 8'h14;

  typedef enum logic [2:0] {
    M_POWER_UP,
    M_STANDBY,
    M_START_MEAS,
    M_MEASURE,
    M_GO_SLEEP,
    M_SLEEP,
    M_WAKING
  } mode_e;

  localparam mode_e MODE_RESET = M_POWER_UP;

  typedef struct packed {
    logic [1:0] op_mode;
    logic [2:0] conversion_averaging_select;
    logic [2:0] mag_channel_enable;
    logic       temperature_channel_enable;
    logic [1:0] magnet_temp_coefficient_select;
  } sense_cfg_s;

  typedef struct packed {
    mode_e mode;
    logic  i2c_respond;
    logic  wake_event;
    logic  result_valid;
    logic  conv_busy;
  } seq_status_s;

endpackage

//--- bit_sync.sv
// Two-flop synchroniser for pin-level inputs.
`timescale 1ns/10ps
module bit_sync import sensor_seq_pkg::*; #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s q;
  sync_s d;

  always_comb begin
    d = q;
    if (clk_en) begin
      d.meta   = async_in;
      d.stable = q.meta;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.stable;

endmodule

//--- conv_timer.sv
// Conversion interval timer: length from averaging and channel settings.
`timescale 1ns/10ps
module conv_timer import sensor_seq_pkg::*; #(
  parameter int SLOT_CYCLES = CONV_SLOT_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  // Control
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [2:0] avg_sel,
  input  wire logic [2:0] mag_en,
  // Status
  output logic            busy,
  output logic            done
);

  typedef struct packed {
    logic             busy;
    logic             done;
    logic [CNT_W-1:0] cnt;
  } timer_s;

  timer_s q;
  timer_s d;

  // Temperature channel has no say in the length
  function automatic logic [CNT_W-1:0] conv_cycles(input logic [2:0] avg,
                                                    input logic [2:0] en);
    int samples;
    int nch;
    samples = 1 << ((avg > AVG_MAX) ? int'(AVG_MAX) : int'(avg));
    nch     = int'(en[0]) + int'(en[1]) + int'(en[2]);
    if (nch == 0) begin
      nch = 1;
    end
    conv_cycles = CNT_W'(SLOT_CYCLES * (1 + samples * nch));
  endfunction

  always_comb begin
    d      = q;
    d.done = 1'b0;
    if (clk_en) begin
      if (abort) begin
        d.busy = 1'b0;
      end else if (start) begin
        d.busy = 1'b1;
        d.cnt  = conv_cycles(avg_sel, mag_en) - CNT_W'(1);
      end else if (q.busy) begin
        if (q.cnt == '0) begin
          d.busy = 1'b0;
          d.done = 1'b1;
        end else begin
          d.cnt = q.cnt - CNT_W'(1);
        end
      end
    end else begin
      d.done = q.done;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy = q.busy;
  assign done = q.done;

  // Checking aids: length of the running conversion and its settings
  int         run_len;
  logic [2:0] lat_avg;
  int         lat_nch;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run_len <= 0;
      lat_avg <= 3'h0;
      lat_nch <= 1;
    end else if (clk_en) begin
      if (start) begin
        run_len <= 0;
        lat_avg <= avg_sel;
        lat_nch <= (mag_en == 3'h0) ? 1 : int'(mag_en[0]) + int'(mag_en[1]) + int'(mag_en[2]);
      end else if (q.busy) begin
        run_len <= run_len + 1;
      end
    end
  end

  a_single_len: assert property (@(posedge clk) disable iff (!reset_n)
    (done && clk_en && lat_avg == AVG_SINGLE) |-> run_len == SLOT_CYCLES * (1 + lat_nch))
    else $error("averaging 000b conversion length wrong");

  a_avg32_len: assert property (@(posedge clk) disable iff (!reset_n)
    (done && clk_en && lat_avg == AVG_MAX)
      |-> run_len == SLOT_CYCLES * (1 + AVG_MAX_SAMPLES * lat_nch))
    else $error("averaging 101b conversion length wrong");

endmodule

//--- i2c_host_model.sv
// Host controller stand-in: drives the serial clock level and address strobes.
`timescale 1ns/10ps
module i2c_host_model import sensor_seq_pkg::*; (
  // Clock
  input  wire logic clk,
  // Bus side
  output logic      scl_pin,
  output logic      addr_match
);
  int since_addr = WAKE_CYCLES;

  // The bus has a pull-up, so an idle clock line reads high
  initial begin
    scl_pin = 1'b1;
    addr_match = 1'b0;
  end

  // Only this process writes the count; it restarts on the edge that takes the strobe
  always @(posedge clk) begin
    since_addr <= addr_match ? 0 : since_addr + 1;
  end

  task automatic set_scl(input logic v);
    @(posedge clk);
    scl_pin <= v;
  endtask

  // A second addressing waits out the wake start-up of the previous one
  task automatic send_address();
    while (since_addr < WAKE_CYCLES) @(posedge clk);
    @(posedge clk);
    addr_match <= 1'b1;
    @(posedge clk);
    addr_match <= 1'b0;
  endtask
endmodule

//--- sensor_mode_seq_test.sv
// Self-checking bench for the mode sequencer and conversion pacing.
`timescale 1ns/10ps
module sensor_mode_seq_test;
  import sensor_seq_pkg::*;
  localparam int PU = 20;
  localparam int SL = 4;

  logic        clk;
  logic        reset_n;
  logic        clk_en;
  logic        supply_ok;
  logic        scl_pin;
  logic        addr_match;
  sense_cfg_s  cfg;
  seq_status_s status;
  logic [7:0]  temp_coefficient;
  int          errors;
  int          samples_checked;
  int          cycles;
  int          n;
  int          per[6];
  logic [7:0]  tc_exp[4] = '{8'h00, 8'h0c, 8'h00, 8'h14};
  logic [2:0]  avg_tab[6] = '{3'h0, 3'h0, 3'h0, 3'h5, 3'h5, 3'h0};
  logic [2:0]  mag_tab[6] = '{3'h1, 3'h3, 3'h1, 3'h1, 3'h3, 3'h7};

  sensor_mode_seq #(.POWER_UP_CNT(PU), .SLOT_CNT(SL)) u_dut (
    .clk              (clk),
    .reset_n          (reset_n),
    .clk_en           (clk_en),
    .supply_ok        (supply_ok),
    .scl_pin          (scl_pin),
    .addr_match       (addr_match),
    .cfg              (cfg),
    .status           (status),
    .temp_coefficient (temp_coefficient)
  );

  i2c_host_model u_host (
    .clk        (clk),
    .scl_pin    (scl_pin),
    .addr_match (addr_match)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Bounded wait: the count tells how many cycles the change took
  task automatic wait_mode(input mode_e m, output int k);
    k = 0;
    while (status.mode !== m && k < 5000) begin
      @(negedge clk);
      k++;
    end
  endtask

  task automatic wait_result(output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (status.result_valid !== 1'b1 && k < 5000);
  endtask

  // Hang guard well above the few thousand cycles the sequence needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      finish_test();
    end
  end

  initial begin
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    clk_en = 1'b1;
    reset_n = 1'b0;
    supply_ok = 1'b0;
    cfg = '0;
    cfg.mag_channel_enable = 3'h1;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      @(posedge clk);
      cfg.magnet_temp_coefficient_select <= 2'(c);
      @(posedge clk);
      @(negedge clk);
      check("temp_coefficient", 32'(temp_coefficient), 32'(tc_exp[c]));
    end
    check("respond in power-up", 32'(status.i2c_respond), 32'h0);
    @(posedge clk);
    supply_ok <= 1'b1;
    wait_mode(M_STANDBY, n);
    check("power-up cycles", 32'(n >= PU && n <= PU + 4), 32'h1);
    check("respond in standby", 32'(status.i2c_respond), 32'h1);
    @(posedge clk);
    cfg.op_mode <= OPMODE_CONTINUOUS;
    wait_mode(M_MEASURE, n);
    check("start-measure cycles", 32'(n >= 2800 && n <= 2803), 32'h1);
    check("respond in measure", 32'(status.i2c_respond), 32'h1);
    // Settings latch at start, so the third pulse closes a full new-setting conversion
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      cfg.conversion_averaging_select <= avg_tab[i];
      cfg.mag_channel_enable <= mag_tab[i];
      cfg.temperature_channel_enable <= (i == 2);
      wait_result(n);
      wait_result(n);
      wait_result(per[i]);
    end
    check("one channel period", 32'(per[0] >= 2 * SL && per[0] <= 2 * SL + 4), 32'h1);
    check("second channel", 32'(per[1] - per[0]), 32'(SL));
    check("third channel", 32'(per[5] - per[0]), 32'(2 * SL));
    check("temperature channel", 32'(per[2] - per[0]), 32'h0);
    check("averaging 101b", 32'(per[3] - per[0]), 32'(31 * SL));
    check("averaging 101b second", 32'(per[4] - per[3]), 32'(32 * SL));
    @(posedge clk);
    cfg.conversion_averaging_select <= AVG_MAX;
    cfg.mag_channel_enable <= 3'h1;
    wait_result(n);
    repeat (20) @(posedge clk);
    @(negedge clk);
    check("busy in measure", 32'(status.conv_busy), 32'h1);
    @(posedge clk);
    cfg.op_mode <= OPMODE_STANDBY;
    // An unaborted conversion would still be busy here for another hundred cycles
    repeat (6) @(negedge clk);
    check("abort busy", 32'(status.conv_busy), 32'h0);
    n = 0;
    repeat (200) begin
      @(negedge clk);
      if (status.result_valid === 1'b1) n++;
    end
    check("aborted result", 32'(n), 32'h0);
    check("abort mode", 32'(status.mode), 32'(M_STANDBY));
    @(posedge clk);
    cfg.op_mode <= OPMODE_SLEEP;
    repeat (400) @(posedge clk);
    @(negedge clk);
    check("sleep held off", 32'(status.mode), 32'(M_GO_SLEEP));
    u_host.set_scl(1'b0);
    repeat (5) @(posedge clk);
    u_host.set_scl(1'b1);
    wait_mode(M_SLEEP, n);
    check("go-sleep cycles", 32'(n >= 800 && n <= 803), 32'h1);
    check("respond in sleep", 32'(status.i2c_respond), 32'h0);
    u_host.send_address();
    n = 0;
    while (status.wake_event !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    check("wake pulse", 32'(status.wake_event), 32'h1);
    check("waking mode", 32'(status.mode), 32'(M_WAKING));
    check("no answer to wake", 32'(status.i2c_respond), 32'h0);
    wait_mode(M_STANDBY, n);
    check("wake cycles", 32'(n), 32'd2000);
    check("respond after wake", 32'(status.i2c_respond), 32'h1);
    u_host.send_address();
    repeat (3) begin
      @(negedge clk);
      check("address in standby", 32'(status.wake_event), 32'h0);
    end
    // Frozen enable: the supply drop must stay unseen until the enable returns
    @(posedge clk);
    clk_en <= 1'b0;
    supply_ok <= 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    check("frozen mode", 32'(status.mode), 32'(M_STANDBY));
    check("frozen respond", 32'(status.i2c_respond), 32'h1);
    @(posedge clk);
    clk_en <= 1'b1;
    wait_mode(M_POWER_UP, n);
    check("supply loss", 32'(n <= 4), 32'h1);
    finish_test();
  end
endmodule
